// ===== hw/clock_monitor_pkg.sv
// Constants, register map and bus carriers for the clock integrity monitor.
// Assumes a single 250 MHz fabric clock and a 32-bit AXI4-Lite register bus.
package clock_monitor_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = ADDR_W - 2;
    localparam int STATUS_W = 11;
    localparam int WINDOW_W = 14;
    localparam int OPMODE_W = 3;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h1d8;
    localparam logic [IDX_W-1:0] IDX_WINDOW = 10'h1d9;
    localparam logic [IDX_W-1:0] IDX_EXPECTED = 10'h1da;
    localparam logic [IDX_W-1:0] IDX_FAST_THR = 10'h1db;
    localparam logic [IDX_W-1:0] IDX_SLOW_THR = 10'h1dc;
    localparam logic [IDX_W-1:0] IDX_SYS_CAPT = 10'h1dd;
    localparam logic [IDX_W-1:0] IDX_SYNTH_CAPT = 10'h1de;
    localparam logic [IDX_W-1:0] IDX_MODE = 10'h1df;

    // Reset values
    localparam logic [WINDOW_W-1:0] RST_WINDOW = 14'h30d3;
    localparam logic [REG_W-1:0] RST_EXPECTED = 16'hf423;
    localparam logic [REG_W-1:0] RST_FAST_THR = 16'h0044;
    localparam logic [REG_W-1:0] RST_SLOW_THR = 16'hf3df;
    localparam logic [REG_W-1:0] RST_CAPTURE = 16'hf423;
    localparam logic [OPMODE_W-1:0] RST_OPMODE = 3'h0;

    // Status flag positions
    localparam int BIT_RESET_FAULT = 0;
    localparam int BIT_PM_FAULT = 1;
    localparam int BIT_ADC_DEAD = 2;
    localparam int BIT_RECOV_DEAD = 3;
    localparam int BIT_SYNTH_DEAD = 4;
    localparam int BIT_SYNTH_PPM = 5;
    localparam int BIT_SYNTH_FREQ = 6;
    localparam int BIT_LINE_DEAD = 7;
    localparam int BIT_SYS_DEAD = 8;
    localparam int BIT_SYS_PPM = 9;
    localparam int BIT_SYS_FREQ = 10;

    // Mode register fields
    localparam int BIT_MAC_SEL = 5;
    localparam int OPMODE_LSB = 0;
    localparam logic [OPMODE_W-1:0] OPMODE_RGMII_COPPER = 3'h0;

    // Watched clock slots in the sampled vector
    localparam int CK_SYS = 0;
    localparam int CK_SYNTH = 1;
    localparam int CK_LINE = 2;
    localparam int CK_RECOV = 3;
    localparam int CK_ADC0 = 4;

    // Reference tick timing: 25 MHz reference from the 250 MHz clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int REF_PERIOD_NS = 40;
    localparam int REF_DIV_CYCLES = (REF_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int REF_DIV_W = 4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

endpackage

// ===== hw/clock_ppm_integrity_monitor.sv
// Clock integrity and fault status monitor with its AXI4-Lite register slave.
// Assumes watched clocks and fault levels arrive as asynchronous pins, sampled here.
`timescale 1ns/1ps
`default_nettype none

module clock_ppm_integrity_monitor #(
    parameter int NUM_ADC_CH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire clock_monitor_pkg::axi_req_s axiReq,
    output clock_monitor_pkg::axi_rsp_s axiRsp,
    input wire logic sysClkPin,
    input wire logic synthClkPin,
    input wire logic lineDriverClkPin,
    input wire logic recoveredClkPin,
    input wire logic [NUM_ADC_CH-1:0] adcClkPin,
    input wire logic sysLockOkPin,
    input wire logic synthLockOkPin,
    input wire logic powerMgmtFaultPin,
    input wire logic resetLogicFaultPin,
    output logic macIfSelMii,
    output logic [clock_monitor_pkg::OPMODE_W-1:0] operationModeCode
);

    localparam int NUM_CLK = clock_monitor_pkg::CK_ADC0 + NUM_ADC_CH;
    localparam int LV_SYS_LOCK = NUM_CLK;
    localparam int LV_SYNTH_LOCK = NUM_CLK + 1;
    localparam int LV_PM_FAULT = NUM_CLK + 2;
    localparam int LV_RST_FAULT = NUM_CLK + 3;
    localparam int NUM_IN = NUM_CLK + 4;
    localparam int RW = clock_monitor_pkg::REG_W;
    localparam int IW = clock_monitor_pkg::IDX_W;

    // Refuse settings the logic cannot serve
    if (NUM_ADC_CH < 1 || NUM_ADC_CH > 16) begin : g_bad_adc
        $error("NUM_ADC_CH must be between 1 and 16");
    end

    // Byte-lane merge of a 16-bit register
    function automatic logic [RW-1:0] laneMerge(input logic [RW-1:0] old, input logic [RW-1:0] data,
                                                input logic [1:0] strb);
        laneMerge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    // Whether an index lands on a mapped register
    function automatic logic isMapped(input logic [IW-1:0] idx);
        isMapped = (idx >= clock_monitor_pkg::IDX_STATUS) && (idx <= clock_monitor_pkg::IDX_MODE);
    endfunction

    logic [NUM_IN-1:0] syncA;
    logic [NUM_IN-1:0] syncB;
    logic [NUM_CLK-1:0] prevClk;
    logic [NUM_CLK-1:0] seen;
    logic [clock_monitor_pkg::REF_DIV_W-1:0] refDiv;
    logic [clock_monitor_pkg::WINDOW_W-1:0] refCount;
    logic [clock_monitor_pkg::WINDOW_W-1:0] windowCount;
    logic [RW-1:0] expectedCount;
    logic [RW-1:0] fastThreshold;
    logic [RW-1:0] slowThreshold;
    logic [RW-1:0] monCnt [2];
    logic [RW-1:0] capture [2];
    logic [clock_monitor_pkg::STATUS_W-1:0] statusFlags;
    logic awHeld;
    logic wHeld;
    logic [IW-1:0] wrIdx;
    logic [RW-1:0] wrData;
    logic [1:0] wrStrb;

    // Input synchronisers; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        syncA <= {resetLogicFaultPin, powerMgmtFaultPin, synthLockOkPin, sysLockOkPin,
                  adcClkPin, recoveredClkPin, lineDriverClkPin, synthClkPin, sysClkPin};
        syncB <= syncA;
        prevClk <= syncB[NUM_CLK-1:0];
    end

    // Edge and activity decode
    wire [NUM_CLK-1:0] clkNow = syncB[NUM_CLK-1:0];
    wire [NUM_CLK-1:0] toggled = clkNow ^ prevClk;
    wire [NUM_CLK-1:0] active = seen | toggled;
    wire [1:0] risen = clkNow[1:0] & ~prevClk[1:0];
    wire adcAllActive = &active[NUM_CLK-1:clock_monitor_pkg::CK_ADC0];

    // Reference tick divider and window counter
    wire refTick = (refDiv == clock_monitor_pkg::REF_DIV_W'(clock_monitor_pkg::REF_DIV_CYCLES - 1));
    wire rollover = refTick && (refCount == '0);

    // Activity memory over one window, restarted at rollover
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seen <= '0;
        end else begin
            seen <= rollover ? toggled : active;
        end
    end

    // Monitor counters and captures for system and synthesizer clocks
    wire [1:0] inBand;
    for (genvar i = 0; i < 2; i++) begin : g_mon
        assign inBand[i] = (monCnt[i] > fastThreshold) && (monCnt[i] < slowThreshold);
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                monCnt[i] <= '0;
                capture[i] <= clock_monitor_pkg::RST_CAPTURE;
            end else if (rollover) begin
                capture[i] <= monCnt[i];
                monCnt[i] <= {{(RW-1){1'b0}}, risen[i]};
            end else if (risen[i]) begin
                monCnt[i] <= monCnt[i] + 1'b1;
            end
        end
    end

    // Flag set events
    wire [clock_monitor_pkg::STATUS_W-1:0] flagSet;
    assign flagSet[clock_monitor_pkg::BIT_RESET_FAULT] = syncB[LV_RST_FAULT];
    assign flagSet[clock_monitor_pkg::BIT_PM_FAULT] = syncB[LV_PM_FAULT];
    assign flagSet[clock_monitor_pkg::BIT_ADC_DEAD] = rollover && !adcAllActive;
    assign flagSet[clock_monitor_pkg::BIT_RECOV_DEAD] = rollover && !active[clock_monitor_pkg::CK_RECOV];
    assign flagSet[clock_monitor_pkg::BIT_SYNTH_DEAD] = rollover && !active[clock_monitor_pkg::CK_SYNTH];
    assign flagSet[clock_monitor_pkg::BIT_SYNTH_PPM] = rollover && inBand[1];
    assign flagSet[clock_monitor_pkg::BIT_SYNTH_FREQ] = !syncB[LV_SYNTH_LOCK];
    assign flagSet[clock_monitor_pkg::BIT_LINE_DEAD] = rollover && !active[clock_monitor_pkg::CK_LINE];
    assign flagSet[clock_monitor_pkg::BIT_SYS_DEAD] = rollover && !active[clock_monitor_pkg::CK_SYS];
    assign flagSet[clock_monitor_pkg::BIT_SYS_PPM] = rollover && inBand[0];
    assign flagSet[clock_monitor_pkg::BIT_SYS_FREQ] = !syncB[LV_SYS_LOCK];

    // Write channel decode
    wire awTake = axiReq.awvalid && axiRsp.awready;
    wire wTake = axiReq.wvalid && axiRsp.wready;
    wire doWrite = awHeld && wHeld && !axiRsp.bvalid;
    wire bDone = axiRsp.bvalid && axiReq.bready;
    wire wrStatus = doWrite && (wrIdx == clock_monitor_pkg::IDX_STATUS);
    wire wrWindow = doWrite && (wrIdx == clock_monitor_pkg::IDX_WINDOW);
    wire wrExpected = doWrite && (wrIdx == clock_monitor_pkg::IDX_EXPECTED);
    wire wrFast = doWrite && (wrIdx == clock_monitor_pkg::IDX_FAST_THR);
    wire wrSlow = doWrite && (wrIdx == clock_monitor_pkg::IDX_SLOW_THR);
    wire wrMode = doWrite && (wrIdx == clock_monitor_pkg::IDX_MODE);
    wire [RW-1:0] clrMask = wrStatus ? laneMerge('0, wrData, wrStrb) : '0;
    wire [RW-1:0] modeMerged = laneMerge(RW'({macIfSelMii, 2'b00, operationModeCode}), wrData, wrStrb);
    wire [RW-1:0] windowMerged = laneMerge(RW'(windowCount), wrData, wrStrb);

    // Reference tick divider and window counter
    // A new window length restarts the count at once, else the old long window must run out first
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            refDiv <= '0;
            refCount <= clock_monitor_pkg::RST_WINDOW;
        end else begin
            refDiv <= refTick ? '0 : refDiv + 1'b1;
            if (wrWindow) begin
                refCount <= windowMerged[clock_monitor_pkg::WINDOW_W-1:0];
            end else if (rollover) begin
                refCount <= windowCount;
            end else if (refTick) begin
                refCount <= refCount - 1'b1;
            end
        end
    end

    // Sticky status: a set in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            statusFlags <= '0;
        end else begin
            statusFlags <= (statusFlags & ~clrMask[clock_monitor_pkg::STATUS_W-1:0]) | flagSet;
        end
    end

    // Write address and data holding
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wrIdx <= '0;
            wrData <= '0;
            wrStrb <= '0;
        end else begin
            if (awTake) begin
                awHeld <= 1'b1;
                wrIdx <= axiReq.awaddr[clock_monitor_pkg::ADDR_W-1:2];
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (wTake) begin
                wHeld <= 1'b1;
                wrData <= axiReq.wdata[RW-1:0];
                wrStrb <= axiReq.wstrb[1:0];
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // Writable configuration registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            windowCount <= clock_monitor_pkg::RST_WINDOW;
            expectedCount <= clock_monitor_pkg::RST_EXPECTED;
            fastThreshold <= clock_monitor_pkg::RST_FAST_THR;
            slowThreshold <= clock_monitor_pkg::RST_SLOW_THR;
            macIfSelMii <= 1'b0;
            operationModeCode <= clock_monitor_pkg::RST_OPMODE;
        end else begin
            if (wrWindow) begin
                windowCount <= windowMerged[clock_monitor_pkg::WINDOW_W-1:0];
            end
            if (wrExpected) begin
                expectedCount <= laneMerge(expectedCount, wrData, wrStrb);
            end
            if (wrFast) begin
                fastThreshold <= laneMerge(fastThreshold, wrData, wrStrb);
            end
            if (wrSlow) begin
                slowThreshold <= laneMerge(slowThreshold, wrData, wrStrb);
            end
            if (wrMode) begin
                macIfSelMii <= modeMerged[clock_monitor_pkg::BIT_MAC_SEL];
                operationModeCode <= modeMerged[clock_monitor_pkg::OPMODE_LSB +: clock_monitor_pkg::OPMODE_W];
            end
        end
    end

    // Read decode
    wire arTake = axiReq.arvalid && axiRsp.arready;
    wire rDone = axiRsp.rvalid && axiReq.rready;
    wire [IW-1:0] rdIdx = axiReq.araddr[clock_monitor_pkg::ADDR_W-1:2];
    wire [RW-1:0] rdValue =
        (rdIdx == clock_monitor_pkg::IDX_STATUS) ? RW'(statusFlags) :
        (rdIdx == clock_monitor_pkg::IDX_WINDOW) ? RW'(windowCount) :
        (rdIdx == clock_monitor_pkg::IDX_EXPECTED) ? expectedCount :
        (rdIdx == clock_monitor_pkg::IDX_FAST_THR) ? fastThreshold :
        (rdIdx == clock_monitor_pkg::IDX_SLOW_THR) ? slowThreshold :
        (rdIdx == clock_monitor_pkg::IDX_SYS_CAPT) ? capture[0] :
        (rdIdx == clock_monitor_pkg::IDX_SYNTH_CAPT) ? capture[1] :
        (rdIdx == clock_monitor_pkg::IDX_MODE) ? RW'({macIfSelMii, 2'b00, operationModeCode}) :
        '0;

    // Write and read handshakes and responses
    // One process owns the whole response struct, so no field has a second driver
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            axiRsp.awready <= 1'b1;
            axiRsp.wready <= 1'b1;
            axiRsp.bvalid <= 1'b0;
            axiRsp.bresp <= clock_monitor_pkg::RESP_OKAY;
            axiRsp.arready <= 1'b1;
            axiRsp.rvalid <= 1'b0;
            axiRsp.rdata <= '0;
            axiRsp.rresp <= clock_monitor_pkg::RESP_OKAY;
        end else begin
            if (awTake) begin
                axiRsp.awready <= 1'b0;
            end else if (bDone) begin
                axiRsp.awready <= 1'b1;
            end
            if (wTake) begin
                axiRsp.wready <= 1'b0;
            end else if (bDone) begin
                axiRsp.wready <= 1'b1;
            end
            if (doWrite) begin
                axiRsp.bvalid <= 1'b1;
                axiRsp.bresp <= isMapped(wrIdx) ? clock_monitor_pkg::RESP_OKAY : clock_monitor_pkg::RESP_SLVERR;
            end else if (bDone) begin
                axiRsp.bvalid <= 1'b0;
            end
            if (arTake) begin
                axiRsp.arready <= 1'b0;
                axiRsp.rvalid <= 1'b1;
                axiRsp.rdata <= clock_monitor_pkg::DATA_W'(rdValue);
                axiRsp.rresp <= isMapped(rdIdx) ? clock_monitor_pkg::RESP_OKAY : clock_monitor_pkg::RESP_SLVERR;
            end else if (rDone) begin
                axiRsp.arready <= 1'b1;
                axiRsp.rvalid <= 1'b0;
            end
        end
    end

    // Checks on the monitor behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_roll_no_line;
        rollover && !active[clock_monitor_pkg::CK_LINE];
    endsequence

    a_line_dead_flag: assert property (s_roll_no_line |=> statusFlags[clock_monitor_pkg::BIT_LINE_DEAD])
        else $error("line driver clock dead flag not set");

    a_synth_lock_flag: assert property (!syncB[LV_SYNTH_LOCK] |=> statusFlags[clock_monitor_pkg::BIT_SYNTH_FREQ])
        else $error("synthesizer lock loss not latched");

    a_sys_lock_flag: assert property (!syncB[LV_SYS_LOCK] |=> statusFlags[clock_monitor_pkg::BIT_SYS_FREQ])
        else $error("system lock loss not latched");

    a_ppm_band_flag: assert property (rollover && inBand[1] |=> statusFlags[clock_monitor_pkg::BIT_SYNTH_PPM])
        else $error("ppm lock loss not latched in band");

    a_flag_no_clear: assert property (!wrStatus |=> (($past(statusFlags) & ~statusFlags) == '0))
        else $error("status flag dropped without write one");

    a_capture_synth: assert property (rollover |=> capture[1] == $past(monCnt[1]))
        else $error("synthesizer capture wrong");

    a_mon_restart: assert property (rollover |=> monCnt[0] <= RW'(1))
        else $error("monitor counter not restarted");

    a_ref_reload: assert property (rollover && !wrWindow |=> refCount == windowCount)
        else $error("reference counter not reloaded");

    sequence s_quiet_ticks;
        !refTick [*8];
    endsequence

    a_tick_spacing: assert property (refTick |=> s_quiet_ticks ##1 !refTick ##1 refTick)
        else $error("reference tick spacing wrong");

    a_mac_select: assert property (wrMode && wrStrb[0] |=>
        macIfSelMii == $past(wrData[clock_monitor_pkg::BIT_MAC_SEL]))
        else $error("interface select not updated");

    a_opmode_write: assert property (wrMode && wrStrb[0] |=>
        operationModeCode == $past(wrData[clock_monitor_pkg::OPMODE_LSB +: clock_monitor_pkg::OPMODE_W]))
        else $error("operation mode code not updated");

    // Fault levels latch one cycle after they leave the synchroniser
    a_pm_fault_flag: assert property (syncB[LV_PM_FAULT] |=> statusFlags[clock_monitor_pkg::BIT_PM_FAULT])
        else $error("power management fault not latched");

    a_rst_fault_flag: assert property (syncB[LV_RST_FAULT] |=> statusFlags[clock_monitor_pkg::BIT_RESET_FAULT])
        else $error("reset logic fault not latched");

    // Inactivity flags latch at the rollover that closes a quiet window
    a_synth_dead_flag: assert property (rollover && !active[clock_monitor_pkg::CK_SYNTH] |=>
        statusFlags[clock_monitor_pkg::BIT_SYNTH_DEAD])
        else $error("synthesizer clock dead flag not set");

    a_recov_dead_flag: assert property (rollover && !active[clock_monitor_pkg::CK_RECOV] |=>
        statusFlags[clock_monitor_pkg::BIT_RECOV_DEAD])
        else $error("recovered clock dead flag not set");

    a_adc_dead_flag: assert property (rollover && !adcAllActive |=> statusFlags[clock_monitor_pkg::BIT_ADC_DEAD])
        else $error("converter clock dead flag not set");

    // System clock count is captured just like the synthesizer one
    a_capture_sys: assert property (rollover |=> capture[0] == $past(monCnt[0]))
        else $error("system clock capture wrong");

    // A write of one with no new event clears the flag
    a_flag_clear: assert property (wrStatus && wrStrb[0] && wrData[0] && !flagSet[0] |=> !statusFlags[0])
        else $error("status flag not cleared by write one");

endmodule // clock_ppm_integrity_monitor

`default_nettype wire

// ===== dv/tb_clock_ppm_integrity_monitor.sv
// Self-checking bench for the clock integrity monitor, register traffic over AXI4-Lite.
// Assumes the design files are compiled first; the bench toggles the watched clock pins itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))

module tb_clock_ppm_integrity_monitor;
    logic ref_clk = 1'b0;
    logic rst_n;
    clock_monitor_pkg::axi_req_s axiReq;
    clock_monitor_pkg::axi_rsp_s axiRsp;
    logic [7:0] clkEn;
    logic [7:0] clkLvl;
    logic phase;
    logic [3:0] badLvl;
    logic macIfSelMii;
    logic [2:0] operationModeCode;
    logic [31:0] rdVal;
    logic [1:0] rdResp;
    logic [1:0] wrResp;
    int numErrors = 0;
    int compares = 0;
    logic [15:0] rstTab [8] = '{16'h0, 16'h30d3, 16'hf423, 16'h0044, 16'hf3df, 16'hf423, 16'hf423, 16'h0};
    logic [15:0] rwTab [4] = '{16'h3fff, 16'hffff, 16'hffff, 16'hffff};
    logic [15:0] deadTab [8] = '{16'h100, 16'h010, 16'h080, 16'h008, 16'h004, 16'h004, 16'h004, 16'h004};
    logic [15:0] badTab [4] = '{16'h001, 16'h002, 16'h040, 16'h400};

    clock_ppm_integrity_monitor #(.NUM_ADC_CH(4)) DUT (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .axiReq(axiReq),
        .axiRsp(axiRsp),
        .sysClkPin(clkLvl[0]),
        .synthClkPin(clkLvl[1]),
        .lineDriverClkPin(clkLvl[2]),
        .recoveredClkPin(clkLvl[3]),
        .adcClkPin(clkLvl[7:4]),
        .sysLockOkPin(~badLvl[3]),
        .synthLockOkPin(~badLvl[2]),
        .powerMgmtFaultPin(badLvl[1]),
        .resetLogicFaultPin(badLvl[0]),
        .macIfSelMii(macIfSelMii),
        .operationModeCode(operationModeCode)
    );

    // Clock generation
    always #2 ref_clk = ~ref_clk;

    // Watched clocks: one level change every two cycles when enabled
    always @(posedge ref_clk) begin
        phase <= ~phase;
        if (phase) begin
            clkLvl <= clkLvl ^ clkEn;
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge ref_clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= s;
        axiReq.bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid) begin
                wrResp = axiRsp.bresp;
                axiReq.bready <= 1'b0;
                break;
            end
        end
        if (n == 200) `CHK(1'b0, 1'b1);
    endtask

    // One read: address held until taken, data taken with rvalid
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge ref_clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid) begin
                rdVal = axiRsp.rdata;
                rdResp = axiRsp.rresp;
                axiReq.rready <= 1'b0;
                break;
            end
        end
        if (n == 200) `CHK(1'b0, 1'b1);
    endtask

    task automatic giveVerdict();
        $display("compares %0d numErrors %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #(40000 * 4);
        numErrors++;
        giveVerdict();
    end

    // Main sequence
    initial begin
        int i;
        axiReq = '0;
        clkEn = 8'hff;
        clkLvl = 8'h00;
        phase = 1'b0;
        badLvl = 4'h0;
        rst_n = 1'b0;
        idle(12);
        rst_n <= 1'b1;
        // Reset values of the whole map
        for (i = 0; i < 8; i++) begin
            rd(12'h760 + 12'(4 * i));
            `CHK(rdVal, rstTab[i]);
        end
        // Captures ignore writes
        for (i = 0; i < 2; i++) begin
            wr(12'h774 + 12'(4 * i), 32'h0000_1234, 4'hf);
            rd(12'h774 + 12'(4 * i));
            `CHK(rdVal, 16'hf423);
        end
        // Writable widths, then a short window of 5 ticks
        for (i = 0; i < 4; i++) begin
            wr(12'h764 + 12'(4 * i), 32'hffff_ffff, 4'hf);
            rd(12'h764 + 12'(4 * i));
            `CHK(rdVal, rwTab[i]);
            `CHK(wrResp, 2'b00);
        end
        wr(12'h768, 32'hf423, 4'hf);
        wr(12'h76c, 32'h0044, 4'hf);
        wr(12'h770, 32'hf3df, 4'hf);
        wr(12'h764, 32'h0004, 4'hf);
        // Every mode code, select bit following code bit 0
        for (i = 0; i < 8; i++) begin
            wr(12'h77c, {26'h0, i[0], 2'b00, i[2:0]}, 4'hf);
            `CHK(operationModeCode, i[2:0]);
            `CHK(macIfSelMii, i[0]);
            rd(12'h77c);
            `CHK(rdVal, {26'h0, i[0], 2'b00, i[2:0]});
        end
        wr(12'h77c, 32'hffff_ffff, 4'hf);
        rd(12'h77c);
        `CHK(rdVal, 32'h27);
        // Unmapped place refused
        wr(12'h780, 32'h1, 4'hf);
        `CHK(wrResp, 2'b10);
        rd(12'h780);
        `CHK(rdVal, 32'h0);
        `CHK(rdResp, 2'b10);
        // Wait for the first short-window capture
        for (i = 0; i < 300; i++) begin
            rd(12'h778);
            if (rdVal !== 32'h0000_f423) break;
        end
        idle(150);
        wr(12'h760, 32'h7ff, 4'hf);
        idle(150);
        rd(12'h760);
        `CHK(rdVal, 32'h0);
        for (i = 0; i < 2; i++) begin
            rd(12'h774 + 12'(4 * i));
            `CHK(rdVal >= 12 && rdVal <= 13, 1'b1);
        end
        // Each watched clock stopped in turn
        for (i = 0; i < 8; i++) begin
            clkEn <= ~(8'h01 << i);
            idle(150);
            rd(12'h760);
            `CHK(rdVal, deadTab[i]);
            clkEn <= 8'hff;
            idle(150);
            wr(12'h760, 32'h7ff, 4'hf);
            rd(12'h760);
            `CHK(rdVal, 32'h0);
        end
        // Fault and lock pins pulsed: sticky, zero write keeps, one write clears
        for (i = 0; i < 4; i++) begin
            badLvl <= 4'h1 << i;
            idle(4);
            badLvl <= 4'h0;
            idle(4);
            rd(12'h760);
            `CHK(rdVal, badTab[i]);
            wr(12'h760, 32'h0, 4'hf);
            rd(12'h760);
            `CHK(rdVal, badTab[i]);
            wr(12'h760, badTab[i], 4'hf);
            rd(12'h760);
            `CHK(rdVal, 32'h0);
        end
        // Byte strobes gate the clear
        badLvl <= 4'h9;
        idle(4);
        badLvl <= 4'h0;
        idle(4);
        wr(12'h760, 32'h7ff, 4'h2);
        rd(12'h760);
        `CHK(rdVal, 32'h001);
        wr(12'h760, 32'h7ff, 4'h1);
        rd(12'h760);
        `CHK(rdVal, 32'h0);
        // Capture inside the fast/slow band flags ppm loss
        wr(12'h76c, 32'h0005, 4'hf);
        wr(12'h770, 32'h0020, 4'hf);
        idle(150);
        rd(12'h760);
        `CHK(rdVal, 32'h220);
        wr(12'h76c, 32'h0044, 4'hf);
        idle(150);
        wr(12'h760, 32'h7ff, 4'hf);
        idle(150);
        rd(12'h760);
        `CHK(rdVal, 32'h0);
        giveVerdict();
    end
endmodule // tb_clock_ppm_integrity_monitor

`default_nettype wire
